// >>> design/dhs_params.svh
`ifndef DHS_PARAMS_SVH
`define DHS_PARAMS_SVH

// Width of the host command byte
`define DHS_CMD_WIDTH      8
// Width of the synchroniser vector; 10 asynchronous inputs use bits 0 to 9, the rest are tied low
`define DHS_SYNC_WIDTH     16
// Bit positions inside the synchroniser vector
`define DHS_POS_PHASE2     0
`define DHS_POS_HLDA       1
`define DHS_POS_HOST_BUS_READY       2
`define DHS_POS_PRIORITY_CHAIN_IN_N_N    3
`define DHS_POS_HOLD_LINE  4
`define DHS_POS_ADDR_MSB   5
`define DHS_POS_MEM_RD_N   6
`define DHS_POS_MEM_WR_N   7
`define DHS_POS_CMD_STB    8
`define DHS_POS_CMD_RD     9
// Reset values
`define DHS_RST_STAGES     4'h0
`define DHS_RST_CMD_BYTE   8'h00
`define DHS_RST_SYNC       16'h0000

`endif

// >>> design/dhs_pkg.sv
package dhs_pkg;

    typedef struct packed {
        logic qa;
        logic qb;
        logic qc;
        logic qd;
    } dhs_stage_type;

    typedef enum logic [3:0] {
        DHS_ARB_IDLE    = 4'b0001,
        DHS_ARB_START   = 4'b0010,
        DHS_ARB_WON     = 4'b0100,
        DHS_ARB_ABORTED = 4'b1000
    } dhs_arb_type;

endpackage

// >>> design/dhs_sync_if.sv
`timescale 1ns/1ps
interface dhs_sync_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface

// >>> design/dhs_sync.sv
`timescale 1ns/1ps
`include "dhs_params.svh"
module dhs_sync
    import dhs_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic clock,
    input  wire logic rst_n,
    dhs_sync_if.dst   port
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= WIDTH'(`DHS_RST_SYNC);
            sync_reg <= WIDTH'(`DHS_RST_SYNC);
        end else begin
            meta_reg <= port.raw;
            sync_reg <= meta_reg;
        end
    end

    assign port.synced = sync_reg;
endmodule

// >>> design/dhs_sequencer.sv
`timescale 1ns/1ps
`include "dhs_params.svh"
module dhs_sequencer
    import dhs_pkg::*;
#(
    parameter int CMD_WIDTH = `DHS_CMD_WIDTH
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 local_addr_msb,
    input  wire logic                 local_mem_read_n,
    input  wire logic                 local_mem_write_n,
    input  wire logic                 local_cmd_read,
    input  wire logic                 host_cmd_strobe,
    input  wire logic [CMD_WIDTH-1:0] host_cmd_data,
    input  wire logic                 host_phase2_clock,
    input  wire logic                 host_hold_acknowledge,
    input  wire logic                 host_bus_ready,
    input  wire logic                 priority_chain_in_n,
    input  wire logic                 host_hold_request_n_in,
    output logic                      host_hold_request_n_out,
    output logic                      host_hold_request_n_oe,
    output logic                      priority_chain_out_n,
    output logic                      local_cpu_ready_input,
    output logic                      host_bus_drive_en,
    output logic                      data_drive_en,
    output logic                      data_dir_to_host,
    output logic                      bus_wait_status,
    output logic                      host_write_strobe_n,
    output logic                      command_pending_n,
    output logic [CMD_WIDTH-1:0]      command_byte,
    output logic                      dma_active
);
    dhs_sync_if #(.WIDTH(`DHS_SYNC_WIDTH)) sync_bus ();

    dhs_sync #(
        .WIDTH (`DHS_SYNC_WIDTH)
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .port  (sync_bus)
    );

    // Active-low pins cross inverted so a cleared synchroniser reads idle
    always_comb begin
        sync_bus.raw                     = '0;
        sync_bus.raw[`DHS_POS_PHASE2]    = host_phase2_clock;
        sync_bus.raw[`DHS_POS_HLDA]      = host_hold_acknowledge;
        sync_bus.raw[`DHS_POS_HOST_BUS_READY]      = host_bus_ready;
        sync_bus.raw[`DHS_POS_PRIORITY_CHAIN_IN_N_N]   = ~priority_chain_in_n;
        sync_bus.raw[`DHS_POS_HOLD_LINE] = ~host_hold_request_n_in;
        sync_bus.raw[`DHS_POS_ADDR_MSB]  = local_addr_msb;
        sync_bus.raw[`DHS_POS_MEM_RD_N]  = ~local_mem_read_n;
        sync_bus.raw[`DHS_POS_MEM_WR_N]  = ~local_mem_write_n;
        sync_bus.raw[`DHS_POS_CMD_STB]   = host_cmd_strobe;
        sync_bus.raw[`DHS_POS_CMD_RD]    = local_cmd_read;
    end

    logic phase2_s;
    logic hlda_s;
    logic host_bus_ready_s;
    logic priority_chain_in_n_n_s;
    logic hold_line_s;
    logic addr_msb_s;
    logic mem_rd_n_s;
    logic mem_wr_n_s;
    logic cmd_stb_s;
    logic cmd_rd_s;

    assign phase2_s    = sync_bus.synced[`DHS_POS_PHASE2];
    assign hlda_s      = sync_bus.synced[`DHS_POS_HLDA];
    assign host_bus_ready_s      = sync_bus.synced[`DHS_POS_HOST_BUS_READY];
    assign priority_chain_in_n_n_s   = ~sync_bus.synced[`DHS_POS_PRIORITY_CHAIN_IN_N_N];
    assign hold_line_s = ~sync_bus.synced[`DHS_POS_HOLD_LINE];
    assign addr_msb_s  = sync_bus.synced[`DHS_POS_ADDR_MSB];
    assign mem_rd_n_s  = ~sync_bus.synced[`DHS_POS_MEM_RD_N];
    assign mem_wr_n_s  = ~sync_bus.synced[`DHS_POS_MEM_WR_N];
    assign cmd_stb_s   = sync_bus.synced[`DHS_POS_CMD_STB];
    assign cmd_rd_s    = sync_bus.synced[`DHS_POS_CMD_RD];

    // Edge detection on synchronised levels
    logic phase2_prev_reg;
    logic cmd_stb_prev_reg;
    logic cmd_rd_prev_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase2_prev_reg  <= 1'b0;
            cmd_stb_prev_reg <= 1'b0;
            cmd_rd_prev_reg  <= 1'b0;
        end else begin
            phase2_prev_reg  <= phase2_s;
            cmd_stb_prev_reg <= cmd_stb_s;
            cmd_rd_prev_reg  <= cmd_rd_s;
        end
    end

    logic trailing_edge;
    logic cmd_write_event;
    logic cmd_read_event;

    assign trailing_edge   = phase2_prev_reg & ~phase2_s;
    assign cmd_write_event = cmd_stb_s & ~cmd_stb_prev_reg;
    assign cmd_read_event  = cmd_rd_s & ~cmd_rd_prev_reg;

    // Command data resampled twice; held stable while the strobe is high
    logic [CMD_WIDTH-1:0] cmd_data_meta_reg;
    logic [CMD_WIDTH-1:0] cmd_data_sync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_data_meta_reg <= '0;
            cmd_data_sync_reg <= '0;
        end else begin
            cmd_data_meta_reg <= host_cmd_data;
            cmd_data_sync_reg <= cmd_data_meta_reg;
        end
    end

    // Command byte and pending flag; a new write wins over a read
    logic [CMD_WIDTH-1:0] cmd_byte_reg;
    logic                 cmd_pending_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_byte_reg    <= `DHS_RST_CMD_BYTE;
            cmd_pending_reg <= 1'b0;
        end else begin
            if (cmd_write_event) begin
                cmd_byte_reg    <= cmd_data_sync_reg;
                cmd_pending_reg <= 1'b1;
            end else if (cmd_read_event) begin
                cmd_pending_reg <= 1'b0;
            end
        end
    end

    // Transaction request and sequencer clear
    logic dma_req;
    logic hold_req;
    logic sequencer_clear;
    logic shift_mode;

    assign dma_req         = addr_msb_s & (~mem_rd_n_s | ~mem_wr_n_s);
    assign hold_req        = dma_req | cmd_pending_reg;
    assign sequencer_clear = ~hold_req;

    dhs_stage_type stage_reg;
    dhs_arb_type   arb_reg;
    logic          abort_now;

    assign shift_mode = stage_reg.qb & dma_req;
    assign abort_now  = trailing_edge & (arb_reg == DHS_ARB_START) & ~priority_chain_in_n_n_s;

    // Four-stage sequencer; qa, qc and qd step on phase-2 trailing edges, qb sets on hold acknowledge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= `DHS_RST_STAGES;
        end else if (sequencer_clear || abort_now) begin
            stage_reg <= `DHS_RST_STAGES;
        end else begin
            if (!stage_reg.qa && trailing_edge && hold_line_s && priority_chain_in_n_n_s) begin
                stage_reg.qa <= 1'b1;
            end
            if (stage_reg.qa && hlda_s) begin
                stage_reg.qb <= 1'b1;
            end
            if (!dma_req) begin
                stage_reg.qc <= 1'b0;
                stage_reg.qd <= 1'b0;
            end else if (shift_mode && trailing_edge) begin
                stage_reg.qc <= 1'b1;
                stage_reg.qd <= stage_reg.qc;
            end
        end
    end

    // Tracks the one-edge window in which a fresh start may be aborted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arb_reg <= DHS_ARB_IDLE;
        end else begin
            case (arb_reg)
                DHS_ARB_IDLE: begin
                    if (!sequencer_clear && !stage_reg.qa && trailing_edge
                        && hold_line_s && priority_chain_in_n_n_s) begin
                        arb_reg <= DHS_ARB_START;
                    end
                end
                DHS_ARB_START: begin
                    if (sequencer_clear) begin
                        arb_reg <= DHS_ARB_IDLE;
                    end else if (abort_now) begin
                        arb_reg <= DHS_ARB_ABORTED;
                    end else if (trailing_edge) begin
                        arb_reg <= DHS_ARB_WON;
                    end
                end
                DHS_ARB_WON: begin
                    if (!stage_reg.qa) begin
                        arb_reg <= DHS_ARB_IDLE;
                    end
                end
                DHS_ARB_ABORTED: begin
                    arb_reg <= DHS_ARB_IDLE;
                end
                default: begin
                    arb_reg <= DHS_ARB_IDLE;
                end
            endcase
        end
    end

    // Registered pin drivers
    dhs_stage_type stage_next;

    always_comb begin
        stage_next = stage_reg;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_hold_request_n_out <= 1'b1;
            host_hold_request_n_oe  <= 1'b0;
            priority_chain_out_n    <= 1'b1;
            local_cpu_ready_input   <= 1'b1;
            host_bus_drive_en       <= 1'b0;
            data_drive_en           <= 1'b0;
            data_dir_to_host        <= 1'b0;
            bus_wait_status         <= 1'b0;
            host_write_strobe_n     <= 1'b1;
            dma_active              <= 1'b0;
        end else begin
            host_hold_request_n_out <= 1'b0;
            host_hold_request_n_oe  <= stage_next.qa;
            priority_chain_out_n    <= ~(~priority_chain_in_n_n_s | stage_next.qa);
            local_cpu_ready_input   <= ~dma_req | (stage_next.qd & host_bus_ready_s);
            host_bus_drive_en       <= stage_next.qb;
            data_drive_en           <= stage_next.qb & dma_req;
            data_dir_to_host        <= mem_rd_n_s;
            bus_wait_status         <= stage_next.qc;
            host_write_strobe_n     <= ~(stage_next.qc & ~mem_wr_n_s);
            dma_active              <= stage_next.qb & dma_req;
        end
    end

    assign command_pending_n = ~cmd_pending_reg;
    assign command_byte      = cmd_byte_reg;
endmodule

// >>> dv/dhs_asserts.sv
`timescale 1ns/1ps
module dhs_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic priority_chain_in_n,
    input wire logic host_cmd_strobe,
    input wire logic local_cmd_read,
    input wire logic local_mem_read_n,
    input wire logic local_mem_write_n,
    input wire logic host_hold_request_n_out,
    input wire logic host_hold_request_n_oe,
    input wire logic priority_chain_out_n,
    input wire logic local_cpu_ready_input,
    input wire logic host_bus_drive_en,
    input wire logic bus_wait_status,
    input wire logic host_write_strobe_n,
    input wire logic command_pending_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_chain_pass_low: assert property (!priority_chain_in_n [*5] |-> !priority_chain_out_n)
        else $error("chain out high while chain in low");
    a_start_chain_low: assert property ($rose(host_hold_request_n_oe) |-> !priority_chain_out_n)
        else $error("hold started without chain out low");
    a_hold_pulls_low: assert property (host_hold_request_n_oe |-> !host_hold_request_n_out)
        else $error("hold line driven high");
    a_drive_needs_hold: assert property (host_bus_drive_en |-> host_hold_request_n_oe)
        else $error("host buses driven without hold");
    a_wait_after_drive: assert property (bus_wait_status |-> host_bus_drive_en)
        else $error("wait status without bus ownership");
    a_strobe_with_wait: assert property (!host_write_strobe_n |-> bus_wait_status)
        else $error("write strobe outside wait");
    a_wait_stalls_cpu: assert property ($rose(bus_wait_status) |-> !local_cpu_ready_input)
        else $error("cpu running at wait start");
    a_end_releases: assert property
        ((local_mem_read_n && local_mem_write_n && command_pending_n) [*6]
         |-> !bus_wait_status && !host_hold_request_n_oe)
        else $error("hold kept after transfer end");
    a_pending_sets: assert property ($rose(host_cmd_strobe) |-> ##[2:5] !command_pending_n)
        else $error("command pending not set");
    a_pending_clears: assert property
        ($rose(local_cmd_read) && !host_cmd_strobe |-> ##[2:5] command_pending_n)
        else $error("command pending not cleared");

    c_wait_seen: cover property ($rose(bus_wait_status));
    c_write_seen: cover property ($fell(host_write_strobe_n));
    c_pending_seen: cover property ($fell(command_pending_n));
endmodule

bind dhs_sequencer dhs_asserts u_chk (.clock, .rst_n, .priority_chain_in_n, .host_cmd_strobe,
    .local_cmd_read, .local_mem_read_n, .local_mem_write_n, .host_hold_request_n_out,
    .host_hold_request_n_oe, .priority_chain_out_n, .local_cpu_ready_input,
    .host_bus_drive_en, .bus_wait_status, .host_write_strobe_n, .command_pending_n);

// >>> dv/dhs_host_model.sv
`timescale 1ns/1ps
module dhs_host_model (
    input wire logic dut_hold_oe,
    input wire logic dut_hold_out,
    input wire logic other_hold,
    input wire logic slow,
    output logic     phase2,
    output logic     hold_ack,
    output logic     bus_ready,
    output logic     hold_line_n
);
    initial begin
        phase2 = 1'b0;
        hold_ack = 1'b0;
        bus_ready = 1'b1;
    end
    always #62.5 phase2 = ~phase2;
    // Open-drain hold line with pull-up
    assign hold_line_n = ((dut_hold_oe && !dut_hold_out) || other_hold) ? 1'b0 : 1'b1;
    always @(posedge phase2) begin
        hold_ack <= !hold_line_n;
        bus_ready <= !slow || ($urandom_range(0, 2) == 0);
    end
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    import dhs_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, local_addr_msb, local_mem_read_n, local_mem_write_n;
    logic local_cmd_read, host_cmd_strobe, priority_chain_in_n, other_hold, slow, rnd;
    logic [7:0] host_cmd_data, exp_byte, command_byte;
    logic host_phase2_clock, host_hold_acknowledge, host_bus_ready, host_hold_request_n_in;
    logic host_hold_request_n_out, host_hold_request_n_oe, priority_chain_out_n;
    logic local_cpu_ready_input, host_bus_drive_en, data_drive_en, data_dir_to_host;
    logic bus_wait_status, host_write_strobe_n, command_pending_n, dma_active;
    int mismatches, check_count, i;

    dhs_sequencer u_dut (
        .clock                   (clock),
        .rst_n                   (rst_n),
        .local_addr_msb          (local_addr_msb),
        .local_mem_read_n        (local_mem_read_n),
        .local_mem_write_n       (local_mem_write_n),
        .local_cmd_read          (local_cmd_read),
        .host_cmd_strobe         (host_cmd_strobe),
        .host_cmd_data           (host_cmd_data),
        .host_phase2_clock       (host_phase2_clock),
        .host_hold_acknowledge   (host_hold_acknowledge),
        .host_bus_ready          (host_bus_ready),
        .priority_chain_in_n     (priority_chain_in_n),
        .host_hold_request_n_in  (host_hold_request_n_in),
        .host_hold_request_n_out (host_hold_request_n_out),
        .host_hold_request_n_oe  (host_hold_request_n_oe),
        .priority_chain_out_n    (priority_chain_out_n),
        .local_cpu_ready_input   (local_cpu_ready_input),
        .host_bus_drive_en       (host_bus_drive_en),
        .data_drive_en           (data_drive_en),
        .data_dir_to_host        (data_dir_to_host),
        .bus_wait_status         (bus_wait_status),
        .host_write_strobe_n     (host_write_strobe_n),
        .command_pending_n       (command_pending_n),
        .command_byte            (command_byte),
        .dma_active              (dma_active)
    );
    dhs_host_model u_host (.dut_hold_oe(host_hold_request_n_oe),
        .dut_hold_out(host_hold_request_n_out), .other_hold(other_hold), .slow(slow),
        .phase2(host_phase2_clock), .hold_ack(host_hold_acknowledge),
        .bus_ready(host_bus_ready), .hold_line_n(host_hold_request_n_in));

    always #5 clock = ~clock;

    function logic exp_dir(input logic wr);
        return wr;
    endfunction

    task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task dma(input logic wr, input logic hold_off, input logic pend);
        logic sw, sr;
        sw = 1'b0;
        sr = 1'b0;
        local_addr_msb <= 1'b1;
        local_mem_read_n <= wr;
        local_mem_write_n <= !wr;
        if (hold_off) begin
            priority_chain_in_n <= 1'b0;
            other_hold <= 1'b1;
        end
        cyc(6);
        chk("ready_stall", local_cpu_ready_input, 8'h00);
        if (hold_off) begin
            cyc(60);
            chk("defer_hold", host_hold_request_n_oe, 8'h00);
            chk("chain_pass", priority_chain_out_n, 8'h00);
            priority_chain_in_n <= 1'b1;
            other_hold <= 1'b0;
            for (i = 0; i < 100 && host_hold_request_n_oe !== 1'b1; i++) cyc(1);
            chk("chain_start", priority_chain_out_n, 8'h00);
            priority_chain_in_n <= 1'b0;
            cyc(20);
            chk("abort_hold", host_hold_request_n_oe, 8'h00);
            priority_chain_in_n <= 1'b1;
        end
        for (i = 0; i < 800 && local_cpu_ready_input !== 1'b1; i++) begin
            cyc(1);
            sw = sw | bus_wait_status;
            sr = sr | !host_write_strobe_n;
        end
        chk("ready_run", local_cpu_ready_input, 8'h01);
        chk("data_drive", data_drive_en, 8'h01);
        chk("dma_active", dma_active, 8'h01);
        chk("wait_seen", sw, 8'h01);
        chk("write_strobe", sr, {7'h00, wr});
        chk("hold_req", host_hold_request_n_oe, 8'h01);
        chk("bus_drive", host_bus_drive_en, 8'h01);
        chk("data_dir", data_dir_to_host, {7'h00, exp_dir(wr)});
        local_mem_read_n <= 1'b1;
        local_mem_write_n <= 1'b1;
        local_addr_msb <= 1'($urandom);
        cyc(8);
        chk("wait_end", bus_wait_status, 8'h00);
        chk("drive_end", data_drive_en, 8'h00);
        chk("dma_end", dma_active, 8'h00);
        chk("hold_keep", host_hold_request_n_oe, {7'h00, pend});
        chk("ready_back", local_cpu_ready_input, 8'h01);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {local_addr_msb, local_cmd_read, host_cmd_strobe, other_hold, slow} = 5'h00;
        {local_mem_read_n, local_mem_write_n, priority_chain_in_n} = 3'h7;
        host_cmd_data = 8'h00;
        void'($urandom(71));
        cyc(16);
        rst_n <= 1'b1;
        cyc(4);
        chk("rst_hold", host_hold_request_n_oe, 8'h00);
        chk("rst_chain", priority_chain_out_n, 8'h01);
        dma(1'b0, 1'b0, 1'b0);
        dma(1'b1, 1'b1, 1'b0);
        exp_byte = 8'($urandom);
        host_cmd_data <= exp_byte;
        host_cmd_strobe <= 1'b1;
        cyc(4);
        host_cmd_strobe <= 1'b0;
        cyc(4);
        chk("cmd_pend", command_pending_n, 8'h00);
        chk("cmd_byte", command_byte, exp_byte);
        for (i = 0; i < 100 && host_hold_request_n_oe !== 1'b1; i++) cyc(1);
        chk("cmd_hold", host_hold_request_n_oe, 8'h01);
        dma(1'b1, 1'b0, 1'b1);
        cyc(30);
        chk("cmd_keep", host_hold_request_n_oe, 8'h01);
        local_cmd_read <= 1'b1;
        cyc(4);
        local_cmd_read <= 1'b0;
        cyc(10);
        chk("cmd_clear", command_pending_n, 8'h01);
        chk("cmd_release", host_hold_request_n_oe, 8'h00);
        repeat (8) begin
            rnd = 1'($urandom);
            slow <= 1'($urandom);
            dma(rnd, 1'b0, 1'b0);
        end
        complete_run;
    end

    initial begin
        #200000;
        mismatches++;
        complete_run;
    end
endmodule
